/* hw/tms_i2c_slave.sv */
`default_nettype none

module tms_i2c_slave (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// synchronised bus lines
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_oe,
	// register access
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic o_rd_en,
	output logic [7:0] o_rd_addr,
	input wire logic [7:0] i_rd_data
);
	import tms_pkg::*;

	typedef enum logic [3:0] {
		TMS_I_IDLE, TMS_I_ADDR, TMS_I_ACK_ADDR, TMS_I_PTR, TMS_I_ACK_PTR,
		TMS_I_WDATA, TMS_I_ACK_W, TMS_I_RDATA, TMS_I_RACK
	} tms_i2c_state_t;

	tms_i2c_state_t state;
	logic scl_q, sda_q, rw, master_ack;
	logic [3:0] cnt;
	logic [7:0] shift, tx, ptr;

	wire scl_rise = i_scl & ~scl_q;
	wire scl_fall = ~i_scl & scl_q;
	wire start_c = scl_q & i_scl & sda_q & ~i_sda;
	wire stop_c = scl_q & i_scl & ~sda_q & i_sda;
	wire rx_state = (state == TMS_I_ADDR) | (state == TMS_I_PTR) | (state == TMS_I_WDATA);
	wire [7:0] ptr_inc = ptr + 8'h01;
	wire load_first = scl_fall & (state == TMS_I_ACK_ADDR) & rw;
	wire load_next = scl_fall & (state == TMS_I_RACK) & master_ack;

	assign o_rd_addr = (state == TMS_I_RACK) ? ptr_inc : ptr;
	assign o_rd_en = load_first | load_next;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state <= TMS_I_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rw <= 1'b0;
			master_ack <= 1'b0;
			cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			o_sda_oe <= 1'b0;
			o_wr_en <= 1'b0;
			o_wr_addr <= 8'h00;
			o_wr_data <= 8'h00;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			o_wr_en <= 1'b0;
			if (start_c) begin
				state <= TMS_I_ADDR;
				cnt <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (stop_c) begin
				state <= TMS_I_IDLE;
				o_sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (rx_state) begin
					shift <= {shift[6:0], i_sda};
					cnt <= cnt + 4'h1;
				end
				if (state == TMS_I_RACK) begin
					master_ack <= ~i_sda;
				end
			end else if (scl_fall) begin
				case (state)
					TMS_I_ADDR: begin
						if (cnt == 4'h8) begin
							if (shift[7:1] == TMS_I2C_ADDR) begin
								rw <= shift[0];
								o_sda_oe <= 1'b1;
								state <= TMS_I_ACK_ADDR;
							end else begin
								state <= TMS_I_IDLE;
							end
						end
					end
					TMS_I_ACK_ADDR: begin
						cnt <= 4'h0;
						if (rw) begin
							tx <= {i_rd_data[6:0], 1'b0};
							o_sda_oe <= ~i_rd_data[7];
							state <= TMS_I_RDATA;
						end else begin
							o_sda_oe <= 1'b0;
							state <= TMS_I_PTR;
						end
					end
					TMS_I_PTR: begin
						if (cnt == 4'h8) begin
							ptr <= shift;
							o_sda_oe <= 1'b1;
							state <= TMS_I_ACK_PTR;
						end
					end
					TMS_I_WDATA: begin
						if (cnt == 4'h8) begin
							o_wr_en <= 1'b1;
							o_wr_addr <= ptr;
							o_wr_data <= shift;
							o_sda_oe <= 1'b1;
							state <= TMS_I_ACK_W;
						end
					end
					TMS_I_ACK_PTR, TMS_I_ACK_W: begin
						if (state == TMS_I_ACK_W) begin
							ptr <= ptr_inc;
						end
						cnt <= 4'h0;
						o_sda_oe <= 1'b0;
						state <= TMS_I_WDATA;
					end
					TMS_I_RDATA: begin
						if (cnt == 4'h7) begin
							o_sda_oe <= 1'b0;
							state <= TMS_I_RACK;
						end else begin
							o_sda_oe <= ~tx[7];
							tx <= {tx[6:0], 1'b0};
							cnt <= cnt + 4'h1;
						end
					end
					TMS_I_RACK: begin
						cnt <= 4'h0;
						if (master_ack) begin
							ptr <= ptr_inc;
							tx <= {i_rd_data[6:0], 1'b0};
							o_sda_oe <= ~i_rd_data[7];
							state <= TMS_I_RDATA;
						end else begin
							state <= TMS_I_IDLE;
						end
					end
					default: begin
						state <= TMS_I_IDLE;
					end
				endcase
			end
		end
	end

endmodule // tms_i2c_slave

`default_nettype wire

/* hw/tms_sync.sv */
`default_nettype none

module tms_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			stage1 <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule // tms_sync

`default_nettype wire

/* hw/tms_tof_sequencer.sv */
// Overview of operation
// (R1) power-on reset sets all registers to defaults and idles the sequencer
// (R2) chip select pin is active low and powers the blocks and serial port
// (R3) bit zero of chip disable register disables the chip; zero re-enables
// (R4) enable changes by pin or bit leave other registers untouched
// (R5) sample start trigger begins a measurement; host supplies it as needed
// (R6) start triggers during a running measurement are ignored
// (R7) command 0x49 acts as a sample start trigger
// (R8) command 0xD7 resets every register except the brownout flag
// (R9) command 0xD1 resets the sequencer, clears accumulators, stops sampling
// (R10) completion of each cycle shows on active-low open-drain interrupt
// (R11) reading interrupt status clears it
// (R12) single-shot mode idles after one measurement until the next trigger
// (R13) continuous mode restarts each measurement after the sampling period
// (R14) mode bit zero: zero continuous, one single-shot
// (R15) after reset the mode is continuous
// (R16) continuous mode raises the interrupt after every measurement
// (R17) interval count and range registers together set the sampling period
// (R18) pulsed emitter current scales with range times fine setting
// (R19) threshold current is driven only during integration
// (R20) interval is 450 us times one plus count shifted by skip exponent
// (R21) interrupt stays asserted until the status register is read
`default_nettype none

module tms_tof_sequencer #(
	parameter int TICK_CYCLES = tms_pkg::TMS_TICK_CYCLES,
	parameter int INTEG_CYCLES = tms_pkg::TMS_INTEG_CYCLES
) (
	// clock and power-on reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// control pins
	input wire logic i_chip_select_low_n,
	input wire logic i_sample_start,
	input wire logic i_irq_enable,
	// serial register port
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// interrupt pin, open drain
	output logic o_irq_n_out,
	output logic o_irq_n_oe,
	// emitter and status
	output logic o_chip_active,
	output logic o_integrating,
	output logic [11:0] o_emitter_code,
	output logic [7:0] o_threshold_code
);
	import tms_pkg::*;

	typedef enum logic [1:0] {
		TMS_S_IDLE, TMS_S_INTEG, TMS_S_WAIT
	} tms_seq_state_t;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pins_sync;
	logic cs_n_s, ss_s, scl_s, sda_s, ss_q;

	tms_sync #(
		.WIDTH(4),
		.RST_VAL(4'b1011)
	) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_async({i_chip_select_low_n, i_sample_start, i_scl, i_sda}),
		.o_sync(pins_sync)
	);

	assign cs_n_s = pins_sync[3];
	assign ss_s = pins_sync[2];
	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// ----------------------------------------------------------------
	// serial register port
	// ----------------------------------------------------------------
	logic wr_en, rd_en, sda_oe_i;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	wire port_rst = i_srst | cs_n_s; // (R2)

	tms_i2c_slave u_i2c (
		.i_sys_clk(i_sys_clk),
		.i_srst(port_rst),
		.i_scl(scl_s),
		.i_sda(sda_s),
		.o_sda_oe(sda_oe_i),
		.o_wr_en(wr_en),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_rd_en(rd_en),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data)
	);

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic [7:0] chip_disable_control;
	logic [7:0] sampling_interval_count;
	logic [7:0] sampling_interval_range;
	logic [7:0] sampling_mode_select;
	logic [7:0] interrupt_status;
	logic [7:0] emitter_current_range;
	logic [7:0] emitter_current_fine;
	logic [7:0] emitter_threshold_current;

	wire wr_cmd = wr_en & (wr_addr == TMS_REG_COMMAND);
	wire cmd_start = wr_cmd & (wr_data == TMS_CMD_SOFT_START); // (R7)
	wire cmd_soft_reset = wr_cmd & (wr_data == TMS_CMD_SOFT_RESET); // (R8)
	wire cmd_soft_clear = wr_cmd & (wr_data == TMS_CMD_SOFT_CLEAR); // (R9)
	wire reg_rst = i_srst | cmd_soft_reset; // (R1) (R8)
	wire wr_disable = wr_en & (wr_addr == TMS_REG_CHIP_DISABLE);
	wire wr_count = wr_en & (wr_addr == TMS_REG_INTERVAL_COUNT);
	wire wr_range = wr_en & (wr_addr == TMS_REG_INTERVAL_RANGE);
	wire wr_mode = wr_en & (wr_addr == TMS_REG_MODE_SELECT);
	wire wr_emit_range = wr_en & (wr_addr == TMS_REG_EMIT_RANGE);
	wire wr_emit_fine = wr_en & (wr_addr == TMS_REG_EMIT_FINE);
	wire wr_emit_thresh = wr_en & (wr_addr == TMS_REG_EMIT_THRESH);
	wire rd_status = rd_en & (rd_addr == TMS_REG_INT_STATUS); // (R11)

	assign rd_data =
		(rd_addr == TMS_REG_CHIP_DISABLE) ? chip_disable_control :
		(rd_addr == TMS_REG_INTERVAL_COUNT) ? sampling_interval_count :
		(rd_addr == TMS_REG_INTERVAL_RANGE) ? sampling_interval_range :
		(rd_addr == TMS_REG_MODE_SELECT) ? sampling_mode_select :
		(rd_addr == TMS_REG_INT_STATUS) ? interrupt_status :
		(rd_addr == TMS_REG_EMIT_RANGE) ? emitter_current_range :
		(rd_addr == TMS_REG_EMIT_FINE) ? emitter_current_fine :
		(rd_addr == TMS_REG_EMIT_THRESH) ? emitter_threshold_current :
		8'h00;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// chip enable changes never reach these resets
	always_ff @(posedge i_sys_clk) begin
		if (reg_rst) begin // (R4)
			chip_disable_control <= TMS_RST_CHIP_DISABLE; // (R3)
			sampling_interval_count <= TMS_RST_INTERVAL_COUNT;
			sampling_interval_range <= TMS_RST_INTERVAL_RANGE;
			sampling_mode_select <= TMS_RST_MODE_SELECT; // (R15)
			emitter_current_range <= TMS_RST_EMIT_RANGE;
			emitter_current_fine <= TMS_RST_EMIT_FINE;
			emitter_threshold_current <= TMS_RST_EMIT_THRESH;
		end else begin
			if (wr_disable) begin
				chip_disable_control <= wr_data; // (R3)
			end
			if (wr_count) begin
				sampling_interval_count <= wr_data; // (R17)
			end
			if (wr_range) begin
				sampling_interval_range <= wr_data; // (R17)
			end
			if (wr_mode) begin
				sampling_mode_select <= wr_data; // (R14)
			end
			if (wr_emit_range) begin
				emitter_current_range <= wr_data;
			end
			if (wr_emit_fine) begin
				emitter_current_fine <= wr_data;
			end
			if (wr_emit_thresh) begin
				emitter_threshold_current <= wr_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// chip enable
	// ----------------------------------------------------------------
	wire next_active = ~cs_n_s & ~chip_disable_control[TMS_BIT_CHIP_DISABLE]; // (R2) (R3)
	wire single_mode = sampling_mode_select[TMS_BIT_MODE_SINGLE]; // (R14)

	// ----------------------------------------------------------------
	// trigger detection
	// ----------------------------------------------------------------
	tms_seq_state_t state;
	wire ss_rise = ss_s & ~ss_q;
	wire trigger = ss_rise | cmd_start; // (R5) (R7)
	// reset, the soft reset and soft clear commands and any disable all idle the sequencer
	wire seq_clear = i_srst | cmd_soft_reset | cmd_soft_clear | ~next_active; // (R9)
	wire accept = trigger & (state == TMS_S_IDLE); // (R6)

	// ----------------------------------------------------------------
	// sampling interval
	// ----------------------------------------------------------------
	logic [TMS_TICK_W-1:0] tick_cnt;
	logic [TMS_INTEG_W-1:0] integ_cnt;
	logic [TMS_INTERVAL_W-1:0] interval_cnt;
	logic [TMS_INTERVAL_W-1:0] interval_ticks;
	logic [3:0] skip;
	logic tick;

	assign skip = sampling_interval_range[TMS_SKIP_MSB:0];
	// period in ticks: one plus count shifted by the skip exponent
	assign interval_ticks = ({16'h0000, sampling_interval_count} << skip)
		+ 24'h00_0001; // (R20)
	assign tick = (tick_cnt == TMS_TICK_W'(TICK_CYCLES - 1));
	wire integ_done = (state == TMS_S_INTEG) & (integ_cnt == TMS_INTEG_W'(INTEG_CYCLES - 1));
	wire interval_done = (interval_cnt >= interval_ticks); // (R17)

	// 450 us tick, phase aligned to each accepted start trigger
	always_ff @(posedge i_sys_clk) begin
		if (seq_clear | accept | tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + TMS_TICK_W'(1);
		end
	end

	// ticks since the current measurement started
	always_ff @(posedge i_sys_clk) begin
		if (seq_clear | accept) begin
			interval_cnt <= '0;
		end else if (state == TMS_S_WAIT & interval_done) begin
			interval_cnt <= '0;
		end else if (tick & ~interval_done) begin
			interval_cnt <= interval_cnt + TMS_INTERVAL_W'(1);
		end
	end

	// integration timer, doubles as the accumulator clear point
	always_ff @(posedge i_sys_clk) begin
		if (seq_clear | state != TMS_S_INTEG) begin
			integ_cnt <= '0; // (R9)
		end else begin
			integ_cnt <= integ_cnt + TMS_INTEG_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// measurement sequencer
	// ----------------------------------------------------------------
	// edge detector tracks the pin even while a command or disable holds the sequencer clear; power-on reset holds it low
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ss_q <= 1'b0;
		end else begin
			ss_q <= ss_s;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (seq_clear) begin
			state <= TMS_S_IDLE; // (R1) (R9)
		end else begin
			case (state)
				TMS_S_IDLE: begin
					if (accept) begin
						state <= TMS_S_INTEG; // (R5)
					end
				end
				TMS_S_INTEG: begin
					if (integ_done) begin
						if (single_mode) begin
							state <= TMS_S_IDLE; // (R12)
						end else begin
							state <= TMS_S_WAIT; // (R13)
						end
					end
				end
				TMS_S_WAIT: begin
					if (single_mode) begin
						state <= TMS_S_IDLE; // (R13)
					end else if (interval_done) begin
						state <= TMS_S_INTEG; // (R13)
					end
				end
				default: begin
					state <= TMS_S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	// soft reset: power-on value in every bit but the brownout flag
	logic [7:0] soft_status;
	always_comb begin
		soft_status = TMS_RST_INT_STATUS;
		soft_status[TMS_BIT_BROWNOUT] = interrupt_status[TMS_BIT_BROWNOUT]; // (R8)
	end

	// a completion in the read cycle survives the clear
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			interrupt_status <= TMS_RST_INT_STATUS; // (R1)
		end else if (cmd_soft_reset) begin
			interrupt_status <= soft_status; // (R8)
		end else begin
			if (integ_done) begin
				interrupt_status[TMS_BIT_DONE] <= 1'b1; // (R10) (R16)
			end else if (rd_status) begin
				interrupt_status[TMS_BIT_DONE] <= 1'b0; // (R11)
			end
			if (rd_status) begin
				interrupt_status[TMS_BIT_BROWNOUT] <= 1'b0; // (R11)
			end
		end
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	wire integrating = (state == TMS_S_INTEG);
	wire next_irq_oe = i_irq_enable & interrupt_status[TMS_BIT_DONE]; // (R10) (R21)
	wire [7:0] next_threshold = integrating ? emitter_threshold_current : 8'h00; // (R19)
	// code over 3825 is the fraction of full-scale current
	wire [11:0] emit_product = {8'h00, emitter_current_range[TMS_EMIT_RANGE_MSB:0]}
		* {4'h0, emitter_current_fine}; // (R18)

	// open-drain pins only ever pull low
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_sda_out <= 1'b0;
			o_sda_oe <= 1'b0;
			o_irq_n_out <= 1'b0;
			o_irq_n_oe <= 1'b0;
			o_chip_active <= 1'b0;
			o_integrating <= 1'b0;
			o_emitter_code <= 12'h000;
			o_threshold_code <= 8'h00;
		end else begin
			o_sda_out <= 1'b0;
			o_sda_oe <= sda_oe_i & ~cs_n_s;
			o_irq_n_out <= 1'b0;
			o_irq_n_oe <= next_irq_oe; // (R10) (R21)
			o_chip_active <= next_active;
			o_integrating <= integrating;
			o_emitter_code <= emit_product; // (R18)
			o_threshold_code <= next_threshold; // (R19)
		end
	end

endmodule // tms_tof_sequencer

`default_nettype wire

/* inc/tms_pkg.sv */
`default_nettype none

package tms_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TMS_REG_CHIP_DISABLE = 8'h01;
	localparam logic [7:0] TMS_REG_INTERVAL_COUNT = 8'h11;
	localparam logic [7:0] TMS_REG_INTERVAL_RANGE = 8'h12;
	localparam logic [7:0] TMS_REG_MODE_SELECT = 8'h13;
	localparam logic [7:0] TMS_REG_INT_STATUS = 8'h60;
	localparam logic [7:0] TMS_REG_EMIT_RANGE = 8'h90;
	localparam logic [7:0] TMS_REG_EMIT_FINE = 8'h91;
	localparam logic [7:0] TMS_REG_EMIT_THRESH = 8'h93;
	localparam logic [7:0] TMS_REG_COMMAND = 8'hB0;

	// ----------------------------------------------------------------
	// reset values and command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] TMS_RST_CHIP_DISABLE = 8'h00;
	localparam logic [7:0] TMS_RST_INTERVAL_COUNT = 8'h00;
	localparam logic [7:0] TMS_RST_INTERVAL_RANGE = 8'h00;
	localparam logic [7:0] TMS_RST_MODE_SELECT = 8'h00;
	localparam logic [7:0] TMS_RST_EMIT_RANGE = 8'h00;
	localparam logic [7:0] TMS_RST_EMIT_FINE = 8'h00;
	localparam logic [7:0] TMS_RST_EMIT_THRESH = 8'h00;
	localparam logic [7:0] TMS_RST_INT_STATUS = 8'h80;
	localparam logic [7:0] TMS_CMD_SOFT_START = 8'h49;
	localparam logic [7:0] TMS_CMD_SOFT_RESET = 8'hD7;
	localparam logic [7:0] TMS_CMD_SOFT_CLEAR = 8'hD1;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TMS_BIT_CHIP_DISABLE = 0;
	localparam int TMS_BIT_MODE_SINGLE = 0;
	localparam int TMS_BIT_DONE = 0;
	localparam int TMS_BIT_BROWNOUT = 7;
	localparam int TMS_SKIP_MSB = 3;
	localparam int TMS_EMIT_RANGE_MSB = 3;

	// ----------------------------------------------------------------
	// serial port and timing
	// ----------------------------------------------------------------
	localparam logic [6:0] TMS_I2C_ADDR = 7'h57; // arbitrary value
	localparam int TMS_CLK_PERIOD_NS = 5;
	localparam int TMS_TICK_TIME_NS = 450000;
	localparam int TMS_TICK_CYCLES = TMS_TICK_TIME_NS / TMS_CLK_PERIOD_NS;
	localparam int TMS_INTEG_TIME_NS = 100000;
	localparam int TMS_INTEG_CYCLES = TMS_INTEG_TIME_NS / TMS_CLK_PERIOD_NS;
	localparam int TMS_TICK_W = 17;
	localparam int TMS_INTEG_W = 17;
	localparam int TMS_INTERVAL_W = 24;

endpackage : tms_pkg

`default_nettype wire

/* sim/tms_host_model.sv */
`default_nettype none

module tms_host_model (
	// clock
	input wire logic i_sys_clk,
	// serial bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	import tms_pkg::*;
	logic [7:0] rx;
	logic nak;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
		nak = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	// scl low and high ten cycles each
	task automatic bit_io(input logic b, output logic r);
		step(5);
		o_sda_oe = !b;
		step(5);
		o_scl = 1'b1;
		step(5);
		r = i_sda;
		step(5);
		o_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			rx[i] = r;
		end
		bit_io(1'b1, ack);
	endtask
	task automatic start;
		step(5);
		o_sda_oe = 1'b0;
		step(5);
		o_scl = 1'b1;
		step(5);
		o_sda_oe = 1'b1;
		step(5);
		o_scl = 1'b0;
	endtask
	task automatic stop;
		step(5);
		o_sda_oe = 1'b1;
		step(5);
		o_scl = 1'b1;
		step(5);
		o_sda_oe = 1'b0;
		step(10);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic k0, k1, k2;
		start();
		byte_io({TMS_I2C_ADDR, 1'b0}, k0);
		byte_io(a, k1);
		byte_io(d, k2);
		stop();
		nak = nak | k0 | k1 | k2;
	endtask
	// status service read clears it on the device side
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic k0, k1, k2, k3;
		start();
		byte_io({TMS_I2C_ADDR, 1'b0}, k0);
		byte_io(a, k1);
		start();
		byte_io({TMS_I2C_ADDR, 1'b1}, k2);
		byte_io(8'hFF, k3);
		d = rx;
		stop();
		nak = nak | k0 | k1 | k2 | !k3;
	endtask
endmodule // tms_host_model

`default_nettype wire

/* sim/tms_tof_sequencer_monitor.sv */
`default_nettype none

module tms_tof_sequencer_monitor #(
	parameter int INTEG_CYCLES = 10
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// pins
	input wire logic i_chip_select_low_n,
	input wire logic i_sample_start,
	input wire logic i_irq_enable,
	input wire logic i_scl,
	input wire logic i_sda,
	// design outputs
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic o_irq_n_out,
	input wire logic o_irq_n_oe,
	input wire logic o_chip_active,
	input wire logic o_integrating,
	input wire logic [11:0] o_emitter_code,
	input wire logic [7:0] o_threshold_code
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------
	// helper counters
	// ----------------
	logic scl_q;
	int integ_cnt;
	int since_integ;
	int scl_quiet;
	always_ff @(posedge i_sys_clk) begin
		scl_q <= i_scl;
		integ_cnt <= (o_integrating && !i_srst) ? integ_cnt + 1 : 0;
		since_integ <= o_integrating ? 0 : (i_srst || since_integ > 98) ? 99 : since_integ + 1;
		scl_quiet <= (i_scl != scl_q) ? 0 : (scl_quiet > 98) ? 99 : scl_quiet + 1;
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	AST_RESET_IDLE: assert property ($fell(i_srst) |-> !o_integrating && !o_irq_n_oe
		&& !o_chip_active && !o_sda_oe && o_emitter_code == 12'h000) else $error("reset state");
	AST_CS_OFF: assert property (i_chip_select_low_n [*5] |-> !o_chip_active && !o_sda_oe)
		else $error("active while deselected");
	AST_START_ACTIVE: assert property ($rose(o_integrating) |-> $past(o_chip_active))
		else $error("start while disabled");
	AST_INTEG_LEN: assert property (o_integrating |-> integ_cnt < INTEG_CYCLES)
		else $error("integration too long");
	AST_THRESH: assert property (!o_integrating && !$past(o_integrating)
		|-> o_threshold_code == 8'h00) else $error("threshold outside integration");
	AST_IRQ_DONE: assert property ($fell(o_integrating) && integ_cnt == INTEG_CYCLES
		&& i_irq_enable && o_chip_active |-> ##[0:4] o_irq_n_oe) else $error("no irq");
	AST_IRQ_CAUSE: assert property ($rose(o_irq_n_oe) |-> since_integ <= 4 && i_irq_enable)
		else $error("irq without completion");
	AST_IRQ_HOLD: assert property ($fell(o_irq_n_oe) |-> scl_quiet < 12
		|| $past(i_chip_select_low_n) || !$past(i_irq_enable)) else $error("irq dropped");
	AST_OPEN_DRAIN: assert property (o_irq_n_out == 1'b0 && o_sda_out == 1'b0)
		else $error("open drain drives high");
endmodule // tms_tof_sequencer_monitor

bind tms_tof_sequencer tms_tof_sequencer_monitor #(.INTEG_CYCLES(INTEG_CYCLES)) u_monitor (
	.i_sys_clk, .i_srst, .i_chip_select_low_n, .i_sample_start, .i_irq_enable, .i_scl, .i_sda,
	.o_sda_out, .o_sda_oe, .o_irq_n_out, .o_irq_n_oe, .o_chip_active, .o_integrating,
	.o_emitter_code, .o_threshold_code
);

`default_nettype wire

/* sim/tms_tof_sequencer_tb.sv */
`default_nettype none

module tms_tof_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tms_pkg::*;
	localparam int TICK = 100;
	localparam int INTEG = 10;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_chip_select_low_n = 1'b0;
	logic i_sample_start = 1'b0;
	logic i_irq_enable = 1'b0;
	logic i_scl, host_oe, o_sda_out, o_sda_oe, o_irq_n_out, o_irq_n_oe;
	logic o_chip_active, o_integrating, integ_d;
	logic [11:0] o_emitter_code;
	logic [7:0] o_threshold_code;
	wire logic i_sda = !(host_oe || o_sda_oe);
	wire logic irq_pin = !o_irq_n_oe;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int last_rise = 0;
	int gap = 0;
	int starts = 0;
	int s0;
	logic [7:0] regs [7] = '{TMS_REG_CHIP_DISABLE, TMS_REG_INTERVAL_COUNT,
		TMS_REG_INTERVAL_RANGE, TMS_REG_MODE_SELECT, TMS_REG_EMIT_RANGE,
		TMS_REG_EMIT_FINE, TMS_REG_EMIT_THRESH};

	always #2.5 i_sys_clk = !i_sys_clk;

	tms_tof_sequencer #(.TICK_CYCLES(TICK), .INTEG_CYCLES(INTEG)) uut (
		.i_sys_clk, .i_srst, .i_chip_select_low_n, .i_sample_start, .i_irq_enable, .i_scl,
		.i_sda, .o_sda_out, .o_sda_oe, .o_irq_n_out, .o_irq_n_oe, .o_chip_active,
		.o_integrating, .o_emitter_code, .o_threshold_code
	);
	tms_host_model host (.i_sys_clk, .i_sda, .o_scl(i_scl), .o_sda_oe(host_oe));

	// measurement starts and spacing
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		integ_d <= o_integrating;
		if (o_integrating === 1'b1 && integ_d !== 1'b1) begin
			starts <= starts + 1;
			gap <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk(12'(d), 12'(e));
	endtask
	task automatic pulse_ss;
		i_sample_start = 1'b1;
		step(3);
		i_sample_start = 1'b0;
		step(3);
	endtask
	task automatic wrap_up;
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		step(4);
		i_srst = 1'b0;
		step(3);
		foreach (regs[i]) rchk(regs[i], 8'h00);
		rchk(TMS_REG_INT_STATUS, 8'h80);
		rchk(TMS_REG_INT_STATUS, 8'h00);
		rchk(TMS_REG_COMMAND, 8'h00);
		rchk(8'h20, 8'h00);
		host.wr(TMS_REG_EMIT_RANGE, 8'h0F);
		host.wr(TMS_REG_EMIT_FINE, 8'hFF);
		host.wr(TMS_REG_EMIT_THRESH, 8'h1E);
		chk(o_emitter_code, 12'hEF1);
		chk(12'(o_threshold_code), 12'h000);
		// single shot with interrupt
		i_irq_enable = 1'b1;
		host.wr(TMS_REG_MODE_SELECT, 8'h01);
		s0 = starts;
		pulse_ss();
		chk(12'(o_integrating), 12'h001);
		chk(12'(o_threshold_code), 12'h01E);
		pulse_ss();
		step(300);
		chk(12'(starts - s0), 12'h001);
		chk(12'(irq_pin), 12'h000);
		rchk(TMS_REG_INT_STATUS, 8'h01);
		chk(12'(irq_pin), 12'h001);
		// soft start, interrupt not configured
		i_irq_enable = 1'b0;
		s0 = starts;
		host.wr(TMS_REG_COMMAND, TMS_CMD_SOFT_START);
		step(50);
		chk(12'(starts - s0), 12'h001);
		chk(12'(irq_pin), 12'h001);
		rchk(TMS_REG_INT_STATUS, 8'h01);
		i_irq_enable = 1'b1;
		// continuous sampling
		host.wr(TMS_REG_INTERVAL_COUNT, 8'h01);
		host.wr(TMS_REG_MODE_SELECT, 8'h00);
		s0 = starts;
		step(300);
		chk(12'(starts - s0), 12'h000);
		pulse_ss();
		step(500);
		chk(12'(gap), 12'(2 * TICK));
		chk(12'(irq_pin), 12'h000);
		rchk(TMS_REG_INT_STATUS, 8'h01);
		step(250);
		chk(12'(irq_pin), 12'h000);
		host.wr(TMS_REG_INTERVAL_RANGE, 8'h01);
		step(800);
		chk(12'(gap), 12'(3 * TICK));
		host.wr(TMS_REG_COMMAND, TMS_CMD_SOFT_CLEAR);
		s0 = starts;
		step(800);
		chk(12'(starts - s0), 12'h000);
		// chip disable by bit and pin
		host.wr(TMS_REG_CHIP_DISABLE, 8'h01);
		chk(12'(o_chip_active), 12'h000);
		s0 = starts;
		pulse_ss();
		step(50);
		chk(12'(starts - s0), 12'h000);
		rchk(TMS_REG_INTERVAL_COUNT, 8'h01);
		host.wr(TMS_REG_CHIP_DISABLE, 8'h00);
		chk(12'(o_chip_active), 12'h001);
		i_chip_select_low_n = 1'b1;
		step(10);
		chk(12'(o_chip_active), 12'h000);
		i_chip_select_low_n = 1'b0;
		step(10);
		rchk(TMS_REG_INTERVAL_RANGE, 8'h01);
		// soft reset
		host.wr(TMS_REG_COMMAND, TMS_CMD_SOFT_RESET);
		rchk(TMS_REG_INTERVAL_COUNT, 8'h00);
		rchk(TMS_REG_MODE_SELECT, 8'h00);
		rchk(TMS_REG_INT_STATUS, 8'h00);
		chk(o_emitter_code, 12'h000);
		// brownout flag survives a soft reset
		i_srst = 1'b1;
		step(4);
		i_srst = 1'b0;
		step(3);
		host.wr(TMS_REG_COMMAND, TMS_CMD_SOFT_RESET);
		rchk(TMS_REG_INT_STATUS, 8'h80);
		chk(12'(host.nak), 12'h000);
		wrap_up();
	end
endmodule // tms_tof_sequencer_tb

`default_nettype wire
